// >>> include/tsp_defs.svh
`ifndef TSP_DEFS_SVH
`define TSP_DEFS_SVH

// switching capacity and port counts
`define TSP_CHANNELS 128
`define TSP_BP_LANES 4
`define TSP_SUB_LANES 8
`define TSP_SUB_DUPLEX_LANES 4

// backplane frame length limits, in time slots
`define TSP_SLOTS_MIN 8'h04
`define TSP_SLOTS_MAX 8'h80

// subscriber line framing: eight slots, upper half received
`define TSP_SLD_SLOTS 8

// idle value sent in unconnected slots
`define TSP_IDLE_BYTE 8'hFF

// connection memory: entry valid bit and last entry of a clear walk
`define TSP_CM_VALID_BIT 7
`define TSP_CM_LAST 7'h7F

// receive buffer between backplane and downstream data memory
`define TSP_FIFO_DEPTH 4
`define TSP_FIFO_WIDTH 39

`endif

// >>> include/tsp_pkg.sv
package tsp_pkg;

    // capacity split between port count and bits per frame
    typedef enum logic [1:0] {
        TSP_BP_4X,
        TSP_BP_2X,
        TSP_BP_1X
    } tsp_bp_mode_t;

    // frame-length supervision
    typedef enum logic [1:0] {
        TSP_HUNT,
        TSP_ONE_GOOD,
        TSP_LOCKED
    } tsp_sync_t;

endpackage : tsp_pkg

// >>> rtl/tsp_top.sv
`timescale 1ns/1ps
`include "tsp_defs.svh"

module tsp_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [W-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [W-1:0] out_data_out
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready_out = (cnt_q != (AW+1)'(D));
    assign out_valid_out = (cnt_q != '0);
    assign out_data_out = mem_q[rd_q];
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;

    always_ff @(posedge clk_in)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= (wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : tsp_fifo

////////////////////////////////////////////////////////////////////////////////

module tsp_top (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    // backplane link
    input wire logic backplane_bit_clock_in,
    input wire logic backplane_frame_strobe_in,
    input wire logic [3:0] bp_rx_in,
    output logic [3:0] bp_tx_out,
    output logic [3:0] bp_tx_oe_out,
    output logic [3:0] output_drive_indicator_out,
    // backplane configuration
    input wire logic [1:0] bp_mode_in,
    input wire logic [7:0] bp_slots_in,
    input wire logic bp_double_rate_in,
    input wire logic bp_strobe_fall_in,
    input wire logic bp_data_fall_in,
    input wire logic [9:0] bp_offset_in,
    input wire logic [3:0] bp_idle_grp_in,
    input wire logic bp_standby_in,
    // backplane status
    output logic bp_sync_out,
    output logic bp_sync_change_out,
    output logic bp_rx_ready_out,
    // subscriber side pins
    output logic [3:0] sub_downstream_out,
    output logic [3:0] sub_downstream_oe_out,
    input wire logic [3:0] sub_upstream_in,
    input wire logic [7:0] sub_shared_port_in,
    output logic [7:0] sub_shared_port_out,
    output logic [7:0] sub_shared_port_oe_out,
    // subscriber configuration
    input wire logic sub_bidir_in,
    input wire logic sub_line_framing_in,
    input wire logic [127:0] sub_slot_out_dir_in,
    input wire logic [127:0] sub_slot_idle_in,
    input wire logic sub_open_drain_in,
    input wire logic sub_standby_in,
    // connection memory access
    input wire logic cm_wr_in,
    input wire logic cm_sel_dn_in,
    input wire logic [6:0] cm_addr_in,
    input wire logic [7:0] cm_data_in,
    input wire logic cm_clear_in,
    output logic cm_reset_mode_out,
    // processor write into downstream data memory
    input wire logic dm_wr_in,
    input wire logic [6:0] dm_addr_in,
    input wire logic [7:0] dm_data_in
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!arst_n_in);

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers and link clock edges
    logic [17:0] sy1_q;
    logic [17:0] sy2_q;
    logic bclk_prev_q;
    logic rise;
    logic fall;
    logic [3:0] rx_s;
    logic [3:0] du_s;
    logic [7:0] sip_s;

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            sy1_q <= '0;
            sy2_q <= '0;
            bclk_prev_q <= 1'b0;
        end
        else
        begin
            sy1_q <= {sub_shared_port_in, sub_upstream_in, bp_rx_in, backplane_frame_strobe_in,
                      backplane_bit_clock_in};
            sy2_q <= sy1_q;
            bclk_prev_q <= sy2_q[0];
        end
    end

    assign rise = sy2_q[0] & ~bclk_prev_q;
    assign fall = ~sy2_q[0] & bclk_prev_q;
    assign rx_s = sy2_q[5:2];
    assign du_s = sy2_q[9:6];
    assign sip_s = sy2_q[17:10];

    ////////////////////////////////////////////////////////////////////////////
    // frame timing shared by all ports
    logic fs_lat_q;
    logic fs_edge;
    logic frame_start;
    logic data_edge;
    logic phase_q;
    logic tick;
    logic [9:0] bitcnt_q;
    logic [7:0] slots_eff;
    logic [10:0] frame_bits;
    logic [11:0] expected;
    logic [6:0] slot;
    logic [2:0] bb;
    logic [2:0] msb_idx;
    logic [1:0] pl;
    logic [1:0] sl;
    logic [2:0] nports;
    logic [7:0] idle;

    assign idle = `TSP_IDLE_BYTE;
    assign slots_eff = (bp_slots_in < `TSP_SLOTS_MIN) ? `TSP_SLOTS_MIN :
                       (bp_slots_in > `TSP_SLOTS_MAX) ? `TSP_SLOTS_MAX : bp_slots_in;
    assign frame_bits = {slots_eff, 3'h0};
    assign expected = bp_double_rate_in ? {frame_bits, 1'b0} : {1'b0, frame_bits};
    assign fs_edge = bp_strobe_fall_in ? fall : rise;
    assign frame_start = fs_edge & sy2_q[1] & ~fs_lat_q;
    assign data_edge = bp_data_fall_in ? fall : rise;
    assign tick = data_edge & (~bp_double_rate_in | phase_q) & ~frame_start;
    assign slot = bitcnt_q[9:3];
    assign bb = bitcnt_q[2:0];
    assign msb_idx = ~bb;
    assign sl = sub_bidir_in ? 2'h3 : 2'h2;

    always_comb
    begin
        unique case (tsp_pkg::tsp_bp_mode_t'(bp_mode_in))
            tsp_pkg::TSP_BP_4X: pl = 2'h2;
            tsp_pkg::TSP_BP_2X: pl = 2'h1;
            default: pl = 2'h0;
        endcase
        nports = 3'(3'h1 << pl);
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            fs_lat_q <= 1'b0;
            phase_q <= 1'b0;
            bitcnt_q <= '0;
        end
        else
        begin
            if (fs_edge)
            begin
                fs_lat_q <= sy2_q[1];
            end
            if (frame_start)
            begin
                phase_q <= 1'b0;
                bitcnt_q <= ({1'b0, bp_offset_in} < frame_bits) ? bp_offset_in : '0;
            end
            else
            begin
                if (data_edge)
                begin
                    phase_q <= ~phase_q;
                end
                if (tick)
                begin
                    bitcnt_q <= ({1'b0, bitcnt_q} == frame_bits - 11'h001) ? '0 : bitcnt_q + 10'h001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame length supervision
    logic [11:0] per_q;
    logic seen_q;
    logic chk_bad;
    tsp_pkg::tsp_sync_t st_q;
    tsp_pkg::tsp_sync_t st_d;

    always_comb
    begin
        chk_bad = seen_q & ((frame_start & (per_q != expected)) | (per_q > expected));
        st_d = st_q;
        if (chk_bad)
        begin
            st_d = tsp_pkg::TSP_HUNT;
        end
        else if (frame_start & seen_q)
        begin
            unique case (st_q)
                tsp_pkg::TSP_HUNT: st_d = tsp_pkg::TSP_ONE_GOOD;
                tsp_pkg::TSP_ONE_GOOD: st_d = tsp_pkg::TSP_LOCKED;
                tsp_pkg::TSP_LOCKED: st_d = tsp_pkg::TSP_LOCKED;
                default: st_d = tsp_pkg::TSP_HUNT;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            per_q <= '0;
            seen_q <= 1'b0;
            st_q <= tsp_pkg::TSP_HUNT;
            bp_sync_out <= 1'b0;
            bp_sync_change_out <= 1'b0;
        end
        else
        begin
            if (frame_start)
            begin
                per_q <= {11'h000, rise};
                seen_q <= 1'b1;
            end
            else if (rise && per_q != 12'hFFF)
            begin
                per_q <= per_q + 12'h001;
            end
            st_q <= st_d;
            bp_sync_out <= (st_d == tsp_pkg::TSP_LOCKED);
            bp_sync_change_out <= (st_d == tsp_pkg::TSP_LOCKED) != (st_q == tsp_pkg::TSP_LOCKED);
        end
    end

    AST_SYNC_DROP: assert property ((chk_bad && st_q == tsp_pkg::TSP_LOCKED) |=> !bp_sync_out)
        else $error("sync kept after a bad frame");
    AST_SYNC_EVENT: assert property ((bp_sync_out != $past(bp_sync_out)) |-> bp_sync_change_out)
        else $error("sync change without event pulse");
    AST_FRAME_LEN: assert property ((frame_start && seen_q && per_q != expected) |=> !bp_sync_out)
        else $error("wrong frame length not flagged");

    ////////////////////////////////////////////////////////////////////////////
    // connection memories and their reset mode
    logic [7:0] cm_up_q [`TSP_CHANNELS];
    logic [7:0] cm_dn_q [`TSP_CHANNELS];
    logic [7:0] dm_up_q [`TSP_CHANNELS];
    logic [7:0] dm_dn_q [`TSP_CHANNELS];
    logic clr_busy_q;
    logic [6:0] clr_cnt_q;

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            cm_reset_mode_out <= 1'b1;
            clr_busy_q <= 1'b0;
            clr_cnt_q <= '0;
        end
        else if (clr_busy_q)
        begin
            clr_cnt_q <= clr_cnt_q + 7'h01;
            if (clr_cnt_q == `TSP_CM_LAST)
            begin
                clr_busy_q <= 1'b0;
                cm_reset_mode_out <= 1'b0;
            end
        end
        else if (cm_clear_in)
        begin
            clr_busy_q <= 1'b1;
            clr_cnt_q <= '0;
        end
    end

    // memories keep their contents over reset
    always_ff @(posedge ref_clk_in)
    begin
        if (clr_busy_q)
        begin
            cm_up_q[clr_cnt_q] <= '0;
            cm_dn_q[clr_cnt_q] <= '0;
        end
        else if (cm_wr_in && cm_sel_dn_in)
        begin
            cm_dn_q[cm_addr_in] <= cm_data_in;
        end
        else if (cm_wr_in)
        begin
            cm_up_q[cm_addr_in] <= cm_data_in;
        end
    end

    AST_CM_CLEAR: assert property ($rose(clr_busy_q) |-> ##128 !cm_reset_mode_out)
        else $error("connection clear walk did not end reset mode");

    ////////////////////////////////////////////////////////////////////////////
    // backplane lanes
    logic [7:0] bp_rx_q [`TSP_BP_LANES];
    logic [6:0] bp_ch [`TSP_BP_LANES];
    logic [3:0] bp_bit;
    logic [3:0] bp_drv;
    logic [`TSP_FIFO_WIDTH-1:0] fin;
    logic [`TSP_FIFO_WIDTH-1:0] fout;
    logic fin_ready;
    logic fout_valid;
    logic fout_ready;

    for (genvar p = 0; p < `TSP_BP_LANES; p++)
    begin : g_bp
        logic [7:0] ce;
        logic conn;
        assign bp_ch[p] = 7'(slot << pl) | 7'(p);
        assign ce = cm_up_q[bp_ch[p]];
        assign conn = ce[`TSP_CM_VALID_BIT] & ~cm_reset_mode_out & (3'(p) < nports);
        assign bp_bit[p] = conn ? dm_up_q[ce[6:0]][msb_idx] : idle[msb_idx];
        assign bp_drv[p] = ~bp_standby_in & (3'(p) < nports) &
                           (conn | bp_idle_grp_in[msb_idx[2:1]]);
        assign fin[8*p +: 8] = {bp_rx_q[p][6:0], rx_s[p]};
    end
    assign fin[`TSP_FIFO_WIDTH-1 -: 7] = slot;

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            bp_tx_out <= '0;
            bp_tx_oe_out <= '0;
            output_drive_indicator_out <= '0;
            bp_rx_ready_out <= 1'b0;
            for (int i = 0; i < `TSP_BP_LANES; i++)
            begin
                bp_rx_q[i] <= '0;
            end
        end
        else
        begin
            bp_tx_out <= bp_bit;
            bp_tx_oe_out <= bp_drv;
            output_drive_indicator_out <= bp_drv;
            bp_rx_ready_out <= fin_ready;
            if (tick)
            begin
                for (int i = 0; i < `TSP_BP_LANES; i++)
                begin
                    bp_rx_q[i] <= fin[8*i +: 8];
                end
            end
        end
    end

    tsp_fifo #(
        .W(`TSP_FIFO_WIDTH),
        .D(`TSP_FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_in(ref_clk_in),
        .arst_n_in(arst_n_in),
        .in_valid_in(tick && bb == 3'h7),
        .in_ready_out(fin_ready),
        .in_data_in(fin),
        .out_valid_out(fout_valid),
        .out_ready_in(fout_ready),
        .out_data_out(fout)
    );

    // processor writes take the port, so the buffer drains later
    assign fout_ready = ~dm_wr_in;

    always_ff @(posedge ref_clk_in)
    begin
        if (dm_wr_in)
        begin
            dm_dn_q[dm_addr_in] <= dm_data_in;
        end
        else if (fout_valid)
        begin
            for (int i = 0; i < `TSP_BP_LANES; i++)
            begin
                if (3'(i) < nports)
                begin
                    dm_dn_q[7'(fout[`TSP_FIFO_WIDTH-1 -: 7] << pl) | 7'(i)] <= fout[8*i +: 8];
                end
            end
        end
    end

    AST_BP_STANDBY: assert property (bp_standby_in |=> bp_tx_oe_out == 4'h0)
        else $error("backplane driven in standby");
    AST_BP_IND: assert property (output_drive_indicator_out == bp_tx_oe_out)
        else $error("drive indicator differs from driven state");
    AST_BP_OFFSET: assert property (frame_start |=> bitcnt_q == (({1'b0, $past(bp_offset_in)} <
        $past(frame_bits)) ? $past(bp_offset_in) : 10'h000))
        else $error("frame start did not load offset");
    AST_BP_SLOTS: assert property ({1'b0, bitcnt_q} < frame_bits || $changed(bp_slots_in) ||
        $past(frame_start))
        else $error("bit counter beyond programmed frame");

    ////////////////////////////////////////////////////////////////////////////
    // subscriber lanes
    logic [7:0] sub_rx_q [`TSP_SUB_LANES];
    logic [6:0] sub_ch [`TSP_SUB_LANES];
    logic [7:0] sub_bit;
    logic [7:0] sub_drv;
    logic [7:0] sub_in;
    logic [7:0] sub_we;

    for (genvar p = 0; p < `TSP_SUB_LANES; p++)
    begin : g_sub
        logic [7:0] ce;
        logic conn;
        logic act;
        logic dir_out;
        assign sub_ch[p] = 7'(slot << sl) | 7'(p);
        assign act = sub_bidir_in | (p < `TSP_SUB_DUPLEX_LANES);
        assign dir_out = ~sub_bidir_in | (sub_line_framing_in ? ~slot[2] : sub_slot_out_dir_in[sub_ch[p]]);
        assign ce = cm_dn_q[sub_ch[p]];
        assign conn = ce[`TSP_CM_VALID_BIT] & ~cm_reset_mode_out;
        assign sub_bit[p] = conn ? dm_dn_q[ce[6:0]][msb_idx] : idle[msb_idx];
        assign sub_drv[p] = ~sub_standby_in & act & dir_out & (conn | sub_slot_idle_in[sub_ch[p]]);
        assign sub_in[p] = sub_bidir_in ? sip_s[p] : ((p < `TSP_SUB_DUPLEX_LANES) ? du_s[p % 4] : 1'b0);
        assign sub_we[p] = act & (~sub_bidir_in | ~dir_out);
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            sub_downstream_out <= '0;
            sub_downstream_oe_out <= '0;
            sub_shared_port_out <= '0;
            sub_shared_port_oe_out <= '0;
            for (int i = 0; i < `TSP_SUB_LANES; i++)
            begin
                sub_rx_q[i] <= '0;
            end
        end
        else
        begin
            for (int i = 0; i < `TSP_SUB_LANES; i++)
            begin
                if (i < `TSP_SUB_DUPLEX_LANES)
                begin
                    sub_downstream_out[i % 4] <= sub_bit[i] & ~sub_open_drain_in;
                    sub_downstream_oe_out[i % 4] <= ~sub_bidir_in & sub_drv[i] &
                                                    ~(sub_open_drain_in & sub_bit[i]);
                end
                sub_shared_port_out[i] <= sub_bit[i] & ~sub_open_drain_in;
                sub_shared_port_oe_out[i] <= sub_bidir_in & sub_drv[i] & ~(sub_open_drain_in & sub_bit[i]);
                if (tick)
                begin
                    sub_rx_q[i] <= {sub_rx_q[i][6:0], sub_in[i]};
                end
            end
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        for (int i = 0; i < `TSP_SUB_LANES; i++)
        begin
            if (tick && bb == 3'h7 && sub_we[i])
            begin
                dm_up_q[sub_ch[i]] <= {sub_rx_q[i][6:0], sub_in[i]};
            end
        end
    end

    AST_SUB_STANDBY: assert property (sub_standby_in |=> (sub_downstream_oe_out == 4'h0 &&
        sub_shared_port_oe_out == 8'h00))
        else $error("subscriber side driven in standby");
    AST_SUB_OD: assert property (sub_open_drain_in |=> ((sub_shared_port_out | sub_downstream_out) == 8'h00))
        else $error("open drain output driven high");
    AST_SUB_SLD: assert property ((sub_bidir_in && sub_line_framing_in && slot[2]) |=>
        sub_shared_port_oe_out == 8'h00 || $past(bitcnt_q) != bitcnt_q)
        else $error("receive half of line frame driven");

endmodule : tsp_top

// >>> tb/tsp_bp_partner.sv
`timescale 1ns/1ps
module tsp_bp_partner (
    // frame control
    input wire logic [10:0] bits_in,
    input wire logic short_in,
    // link pins
    output logic clk_out,
    output logic fs_out
);
    int n = 0;
    initial
    begin
        clk_out = 1'b0;
        fs_out = 1'b0;
        #3;
        // free-running bit clock at data rate
        forever
        begin
            #80 clk_out = 1'b1;
            n = (n + 1 >= bits_in - short_in) ? 0 : n + 1;
            #80 clk_out = 1'b0;
            // strobe moves on falling edge, stable at rising
            fs_out = (n == 0);
        end
    end
endmodule : tsp_bp_partner

// >>> tb/tb_tsp_top.sv
`timescale 1ns/1ps
`include "tsp_defs.svh"
`define CHK(nm, ex, got) \
    begin \
        num_checks++; \
        if ((got) !== (ex)) \
        begin \
            fails++; \
            $display("BAD %s exp %h got %h", nm, ex, got); \
        end \
    end
module tb_tsp_top;
    logic ref_clk_in, arst_n_in = 1'b0, bp_double_rate_in = 1'b0, bp_strobe_fall_in = 1'b0;
    logic backplane_bit_clock_in, backplane_frame_strobe_in, bp_data_fall_in = 1'b0;
    logic bp_standby_in = 1'b0, sub_bidir_in = 1'b0, sub_line_framing_in = 1'b0;
    logic sub_open_drain_in = 1'b0, sub_standby_in = 1'b0, cm_wr_in = 1'b0, cm_sel_dn_in = 1'b0;
    logic cm_clear_in = 1'b0, dm_wr_in = 1'b0, short = 1'b0, e;
    logic [1:0] bp_mode_in = 2'h0;
    logic [7:0] bp_slots_in = 8'h04, cm_data_in = 8'h00, dm_data_in = 8'h00;
    logic [7:0] sub_shared_port_in = 8'h00, sub_shared_port_out, sub_shared_port_oe_out;
    logic [6:0] cm_addr_in = 7'h00, dm_addr_in = 7'h00;
    logic [9:0] bp_offset_in = 10'h000;
    logic [3:0] bp_rx_in = 4'h0, bp_idle_grp_in = 4'h0, sub_upstream_in = 4'h0, bp_tx_out;
    logic [3:0] bp_tx_oe_out, output_drive_indicator_out, sub_downstream_out, sub_downstream_oe_out;
    logic [127:0] sub_slot_out_dir_in = '0, sub_slot_idle_in = '0;
    logic bp_sync_out, bp_sync_change_out, bp_rx_ready_out, cm_reset_mode_out;
    logic exp_q[$];
    int fails = 0, num_checks = 0;
    tsp_bp_partner i_bp (.bits_in(11'h020), .short_in(short), .clk_out(backplane_bit_clock_in),
        .fs_out(backplane_frame_strobe_in));
    tsp_top i_dut (.ref_clk_in, .arst_n_in, .backplane_bit_clock_in, .backplane_frame_strobe_in,
        .bp_rx_in, .bp_tx_out, .bp_tx_oe_out, .output_drive_indicator_out, .bp_mode_in, .bp_slots_in,
        .bp_double_rate_in, .bp_strobe_fall_in, .bp_data_fall_in, .bp_offset_in, .bp_idle_grp_in,
        .bp_standby_in, .bp_sync_out, .bp_sync_change_out, .bp_rx_ready_out, .sub_downstream_out,
        .sub_downstream_oe_out, .sub_upstream_in, .sub_shared_port_in, .sub_shared_port_out,
        .sub_shared_port_oe_out, .sub_bidir_in, .sub_line_framing_in, .sub_slot_out_dir_in,
        .sub_slot_idle_in, .sub_open_drain_in, .sub_standby_in, .cm_wr_in, .cm_sel_dn_in, .cm_addr_in,
        .cm_data_in, .cm_clear_in, .cm_reset_mode_out, .dm_wr_in, .dm_addr_in, .dm_data_in);
    initial
    begin
        ref_clk_in = 1'b0;
        forever #4 ref_clk_in = ~ref_clk_in;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask : step
    function automatic logic cond(input int k);
        case (k)
            0: return cm_reset_mode_out === 1'b0;
            1: return bp_rx_ready_out === 1'b0;
            2: return bp_rx_ready_out === 1'b1;
            3: return backplane_frame_strobe_in === 1'b1;
            default: return exp_q.size() == 0;
        endcase
    endfunction : cond
    task automatic wait_until(input int k, input int lim);
        for (int i = 0; i < lim && !cond(k); i++)
            step(1);
        if (!cond(k))
        begin
            fails++;
            $display("BAD wait %0d exp 1 got 0", k);
            conclude();
        end
    endtask : wait_until
    ////////////////////////////////////////////////////////////////////////////
    // far-side data; shared pins resolve against own drive
    always @(posedge ref_clk_in)
    begin
        #1;
        bp_rx_in = 4'($urandom);
        sub_upstream_in = 4'($urandom);
        sub_shared_port_in = (sub_shared_port_oe_out & sub_shared_port_out) |
            (~sub_shared_port_oe_out & 8'($urandom));
    end
    always @(negedge ref_clk_in)
        if (arst_n_in)
        begin
            `CHK("indicator", bp_tx_oe_out, output_drive_indicator_out)
            if (bp_sync_change_out === 1'b1)
            begin
                e = exp_q.size() ? exp_q.pop_front() : 1'bx;
                `CHK("sync", e, bp_sync_out)
            end
        end
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(32'hD162));
        bp_data_fall_in = 1'($urandom);
        bp_strobe_fall_in = 1'($urandom);
        bp_offset_in = 10'($urandom % 32);
        sub_slot_out_dir_in = {4{$urandom}};
        step(80);
        arst_n_in = 1'b1;
        step(1);
        `CHK("cm_reset", 1'b1, cm_reset_mode_out)
        `CHK("bp_oe", 4'h0, bp_tx_oe_out)
        `CHK("sync0", 1'b0, bp_sync_out)
        exp_q.push_back(1'b1);
        cm_wr_in = 1'b1;
        cm_addr_in = 7'($urandom);
        step(1);
        cm_wr_in = 1'b0;
        cm_clear_in = 1'b1;
        step(1);
        cm_clear_in = 1'b0;
        step(127);
        `CHK("cm_busy", 1'b1, cm_reset_mode_out)
        step(1);
        `CHK("cm_done", 1'b0, cm_reset_mode_out)
        bp_idle_grp_in = 4'hF;
        sub_slot_idle_in = '1;
        wait_until(4, 3000);
        step(40);
        `CHK("bp_oe", 4'hF, bp_tx_oe_out)
        `CHK("bp_tx", 4'hF, bp_tx_out)
        `CHK("sub_oe", 4'hF, sub_downstream_oe_out)
        `CHK("sub_dd", 4'hF, sub_downstream_out)
        `CHK("sip_oe", 8'h00, sub_shared_port_oe_out)
        bp_standby_in = 1'b1;
        sub_standby_in = 1'b1;
        step(3);
        `CHK("bp_sb", 4'hF, bp_tx_oe_out ^ 4'hF)
        `CHK("sub_sb", 4'h0, sub_downstream_oe_out)
        // one short frame under standby: sync must still be tracked
        exp_q.push_back(1'b0);
        exp_q.push_back(1'b1);
        wait_until(3, 700);
        step(400);
        short = 1'b1;
        step(400);
        short = 1'b0;
        wait_until(4, 3000);
        `CHK("bp_sb2", 4'h0, bp_tx_oe_out)
        bp_standby_in = 1'b0;
        sub_standby_in = 1'b0;
        sub_open_drain_in = 1'b1;
        step(3);
        `CHK("od_oe", 4'h0, sub_downstream_oe_out)
        `CHK("od_dd", 4'h0, sub_downstream_out)
        for (int i = 0; i < 8; i++)
        begin
            bp_idle_grp_in = 4'($urandom);
            bp_mode_in = 2'($urandom % 3);
            step(100);
        end
        // line framing with one connected slot; longer frame drops sync once
        exp_q.push_back(1'b0);
        bp_slots_in = 8'h08;
        bp_offset_in = 10'h010;
        sub_open_drain_in = 1'b0;
        sub_bidir_in = 1'b1;
        sub_line_framing_in = 1'b1;
        cm_wr_in = 1'b1;
        cm_sel_dn_in = 1'b1;
        cm_addr_in = 7'h10;
        cm_data_in = 8'hFF;
        dm_wr_in = 1'b1;
        dm_addr_in = 7'h7F;
        dm_data_in = 8'h00;
        step(1);
        cm_wr_in = 1'b0;
        dm_wr_in = 1'b0;
        step(30);
        wait_until(3, 700);
        step(40);
        `CHK("sip_oe", 8'hFF, sub_shared_port_oe_out)
        `CHK("sip_out", 8'hFE, sub_shared_port_out)
        `CHK("dd_oe", 4'h0, sub_downstream_oe_out)
        step(320);
        `CHK("sip_rx", 8'h00, sub_shared_port_oe_out)
        // stall the drain until the receive buffer refuses
        dm_wr_in = 1'b1;
        dm_data_in = 8'($urandom);
        wait_until(1, 2000);
        `CHK("rx_full", 1'b0, bp_rx_ready_out)
        dm_wr_in = 1'b0;
        wait_until(2, 20);
        `CHK("sync_q", 0, exp_q.size())
        conclude();
    end
endmodule : tb_tsp_top
